// ==== hdl/curref_defs.svh ====
// Constants for the current reference control block: offsets, fields, resets
// Assumes inclusion by bare name from files under hdl/
`ifndef CURREF_DEFS_SVH
`define CURREF_DEFS_SVH

`define CURREF_CTRL_ADDR      8'hB9
`define CURREF_CFG_ADDR       8'hB9
`define CURREF_CTRL_PAGE      4'h0
`define CURREF_CFG_PAGE       4'hF
`define CURREF_CTRL_RESET     8'h00
`define CURREF_CFG_RESET      8'h00
`define CURREF_DIR_BIT        7
`define CURREF_RANGE_BIT      6
`define CURREF_STEP_MSB       5
`define CURREF_STEP_ZERO      6'h00
`define CURREF_FT_EN_BIT      7
`define CURREF_FT_SEL_MSB     2
`define CURREF_CFG_RW_MASK    8'h87
`define CURREF_FT_SEL_LAST    3'h5
`define CURREF_CHANNELS       6

`endif

// ==== hdl/curref_pkg.sv ====
// Types shared by the current reference control block
// Assumes curref_defs.svh is on the include path
package curref_pkg;
   typedef enum logic {CURREF_SOURCE, CURREF_SINK} curref_dir_type;
   typedef enum logic {CURREF_LOW_POWER, CURREF_HIGH_CURRENT} curref_range_type;
endpackage

// ==== hdl/curref_fine_select.sv ====
// Fine-tune channel selector: picks one counter-array output by code
// Assumes channel outputs are already synchronous to mclk_in
`include "curref_defs.svh"

module curref_fine_select #(
   parameter int CHANNELS = `CURREF_CHANNELS
) (
   input  wire logic [CHANNELS-1:0] channel_pwm_output_in,
   input  wire logic [2:0]          fine_tune_source_select_in,
   output logic                     gate_out,
   output logic                     code_valid_out
);

   // Reserved codes select nothing
   always_comb begin
      gate_out       = 1'b0;
      code_valid_out = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (fine_tune_source_select_in == 3'(i)) begin
            gate_out       = channel_pwm_output_in[i];
            code_valid_out = 1'b1;
         end
      end
   end

endmodule

// ==== hdl/curref_ctrl.sv ====
// Current reference control: two special function registers and the
// registered control word for the analog source/sink stage
// Assumes a single-cycle register port on mclk_in; channel inputs on mclk_in
`include "curref_defs.svh"

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - Zero step count keeps the reference disabled; nonzero count enables it.
// - Writing zero to the whole control register turns output off, clears settings.
// - Control bit 7 picks direction: zero sources, one sinks current.
// - Control bit 6 picks range: zero 1 uA step, one 8 uA step.
// - Control bits 5 to 0 hold step count driving output magnitude.
// - Config bit 7 routes selected channel output to gate fine-adjust cell.
// - The fine-adjust cell weighs two LSBs of step count.
// - Config bits 2 to 0 pick channel 0 to 5; others reserved.
// - Config bits 6 to 3 read zero and ignore writes.
module curref_ctrl #(
   parameter int CHANNELS = `CURREF_CHANNELS
) (
   input  wire logic                mclk_in,
   input  wire logic                rst_in,
   input  wire logic [3:0]          sfr_page_in,
   input  wire logic [7:0]          sfr_addr_in,
   input  wire logic                sfr_write_in,
   input  wire logic                sfr_read_in,
   input  wire logic [7:0]          sfr_wdata_in,
   output logic      [7:0]          sfr_rdata_out,
   output logic                     sfr_hit_out,
   input  wire logic [CHANNELS-1:0] channel_pwm_output_in,
   output logic                     current_reference_enable_out,
   output logic                     current_sink_out,
   output logic                     output_range_select_out,
   output logic      [5:0]          step_count_out,
   output logic                     fine_tune_gate_out
);

   logic [7:0] current_ref_control;
   logic [7:0] current_ref_pwm_config;
   logic       sel_gate;
   logic       sel_valid;
   logic       ctrl_hit;
   logic       cfg_hit;
   curref_pkg::curref_dir_type   dir;
   curref_pkg::curref_range_type range;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode: both registers share an address, split by page
   function automatic logic page_hit(input logic [3:0] page, input logic [7:0] addr,
                                     input logic [3:0] want_page,
                                     input logic [7:0] want_addr);
      page_hit = (page == want_page) && (addr == want_addr);
   endfunction

   assign ctrl_hit    = page_hit(sfr_page_in, sfr_addr_in, `CURREF_CTRL_PAGE, `CURREF_CTRL_ADDR);
   assign cfg_hit     = page_hit(sfr_page_in, sfr_addr_in, `CURREF_CFG_PAGE, `CURREF_CFG_ADDR);
   assign sfr_hit_out = ctrl_hit | cfg_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Control register: whole-byte write, zero write clears everything
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         current_ref_control <= `CURREF_CTRL_RESET;
      end else if (sfr_write_in && ctrl_hit) begin
         current_ref_control <= sfr_wdata_in;
      end
   end

   // Config register: unused bits never stored
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         current_ref_pwm_config <= `CURREF_CFG_RESET;
      end else if (sfr_write_in && cfg_hit) begin
         current_ref_pwm_config <= sfr_wdata_in & `CURREF_CFG_RW_MASK;
      end
   end

   // Read data, registered; unmapped reads return zero
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_read_in && ctrl_hit) begin
         sfr_rdata_out <= current_ref_control;
      end else if (sfr_read_in && cfg_hit) begin
         sfr_rdata_out <= current_ref_pwm_config;
      end else begin
         sfr_rdata_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fine-tune source selection
   curref_fine_select #(
      .CHANNELS (CHANNELS)
   ) u_sel (
      .channel_pwm_output_in      (channel_pwm_output_in),
      .fine_tune_source_select_in (current_ref_pwm_config[`CURREF_FT_SEL_MSB:0]),
      .gate_out                   (sel_gate),
      .code_valid_out             (sel_valid)
   );

   assign dir   = curref_pkg::curref_dir_type'(current_ref_control[`CURREF_DIR_BIT]);
   assign range = curref_pkg::curref_range_type'(current_ref_control[`CURREF_RANGE_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // Registered control word to the analog stage
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         current_reference_enable_out <= 1'b0;
         current_sink_out             <= 1'b0;
         output_range_select_out      <= 1'b0;
         step_count_out               <= 6'h00;
      end else begin
         current_reference_enable_out <=
            current_ref_control[`CURREF_STEP_MSB:0] != `CURREF_STEP_ZERO;
         current_sink_out             <= (dir == curref_pkg::CURREF_SINK);
         output_range_select_out      <= (range == curref_pkg::CURREF_HIGH_CURRENT);
         step_count_out               <= current_ref_control[`CURREF_STEP_MSB:0];
      end
   end

   // Gate for the two-LSB fine cell; off for reserved codes
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fine_tune_gate_out <= 1'b0;
      end else begin
         fine_tune_gate_out <= current_ref_pwm_config[`CURREF_FT_EN_BIT]
                               & sel_valid & sel_gate;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_enable;
      @(posedge mclk_in) disable iff (rst_in)
      current_reference_enable_out == ($past(current_ref_control[5:0]) != 6'h00);
   endproperty
   a_enable: assert property (p_enable) else $error("enable mismatch");

   property p_zero_write;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && ctrl_hit && sfr_wdata_in == 8'h00) |=> ##1
      (!current_reference_enable_out && !current_sink_out && !output_range_select_out);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write not off");

   property p_sink;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && ctrl_hit) |=> ##1 (current_sink_out == $past(sfr_wdata_in[7], 2));
   endproperty
   a_sink: assert property (p_sink) else $error("direction wrong");

   property p_range;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && ctrl_hit) |=> ##1
      (output_range_select_out == $past(sfr_wdata_in[6], 2));
   endproperty
   a_range: assert property (p_range) else $error("range wrong");

   property p_step;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && ctrl_hit) |=> ##1 (step_count_out == $past(sfr_wdata_in[5:0], 2));
   endproperty
   a_step: assert property (p_step) else $error("step count wrong");

   property p_gate_off;
      @(posedge mclk_in) disable iff (rst_in)
      !current_ref_pwm_config[7] |=> !fine_tune_gate_out;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate without enable");

   property p_unused_read;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_read_in && cfg_hit && !ctrl_hit) |=> (sfr_rdata_out[6:3] == 4'h0);
   endproperty
   a_unused_read: assert property (p_unused_read) else $error("unused bits read");

   property p_reserved;
      @(posedge mclk_in) disable iff (rst_in)
      (current_ref_pwm_config[2:0] > 3'h5) |=> !fine_tune_gate_out;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code gates");

   property p_route;
      @(posedge mclk_in) disable iff (rst_in)
      (current_ref_pwm_config[7] && current_ref_pwm_config[2:0] <= 3'h5) |=>
      (fine_tune_gate_out == $past(channel_pwm_output_in[current_ref_pwm_config[2:0]]));
   endproperty
   a_route: assert property (p_route) else $error("channel routing wrong");

   property p_reset_regs;
      @(posedge mclk_in)
      rst_in |=> (current_ref_control == 8'h00 && current_ref_pwm_config == 8'h00);
   endproperty
   a_reset_regs: assert property (p_reset_regs) else $error("reset left a register set");

   property p_reset_outs;
      @(posedge mclk_in)
      rst_in |=> (!current_reference_enable_out && !current_sink_out &&
                  !output_range_select_out && step_count_out == 6'h00 && !fine_tune_gate_out);
   endproperty
   a_reset_outs: assert property (p_reset_outs) else $error("reset left an output set");

   property p_ctrl_write;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && ctrl_hit) |=> (current_ref_control == $past(sfr_wdata_in));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_cfg_write;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_write_in && cfg_hit) |=>
      (current_ref_pwm_config == ($past(sfr_wdata_in) & 8'h87));
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write stored wrong");

   property p_ctrl_read;
      @(posedge mclk_in) disable iff (rst_in)
      (sfr_read_in && ctrl_hit) |=> (sfr_rdata_out == $past(current_ref_control));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

   property p_fine_valid;
      @(posedge mclk_in) disable iff (rst_in)
      !sel_valid |=> !fine_tune_gate_out;
   endproperty
   a_fine_valid: assert property (p_fine_valid) else $error("gate on invalid code");

endmodule

// ==== test/curref_stage_model.sv ====
// Behavioural analog source/sink stage: control word to signed current in uA
// Assumes its inputs are the registered control outputs of the block
module curref_stage_model (
   input  wire logic       enable_in,
   input  wire logic       sink_in,
   input  wire logic       range_in,
   input  wire logic [5:0] step_in,
   input  wire logic       gate_in,
   output int              current_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int mag;
   // Coarse steps plus the two-LSB fine cell, scaled by the range step
   always_comb begin
      mag = (int'(step_in) + (gate_in ? 2 : 0)) * (range_in ? 8 : 1);
      current_out = !enable_in ? 0 : (sink_in ? -mag : mag);
   end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the current reference control block
// Assumes the hdl/ files are compiled first; single clock, sync reset
`include "curref_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk_in = 0, rst_in = 1, wr = 0, rd = 0, en, snk, rng, gate, hit;
   logic [3:0] page = 4'h0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, last;
   logic [5:0] chan = 6'h00, step;
   int         current, err_count = 0, n_compared = 0, cycles = 0;
   curref_ctrl u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .sfr_page_in(page),
      .sfr_addr_in(addr), .sfr_write_in(wr), .sfr_read_in(rd), .sfr_wdata_in(wdata),
      .sfr_rdata_out(rdata), .sfr_hit_out(hit), .channel_pwm_output_in(chan),
      .current_reference_enable_out(en), .current_sink_out(snk),
      .output_range_select_out(rng), .step_count_out(step), .fine_tune_gate_out(gate));
   curref_stage_model u_stage (.enable_in(en), .sink_in(snk), .range_in(rng),
      .step_in(step), .gate_in(gate), .current_out(current));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compare, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One-cycle access from a falling edge; outputs settled two edges on
   task automatic acc(input logic [3:0] pg, input logic [7:0] ad, input logic w,
                      input logic [7:0] d);
      page = pg;
      addr = ad;
      wdata = d;
      wr = w;
      rd = !w;
      @(negedge mclk_in);
      wr = 0;
      rd = 0;
      last = rdata;
      @(negedge mclk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      acc(4'h0, `CURREF_CTRL_ADDR, 0, 8'h00);
      chk(last, `CURREF_CTRL_RESET);
      acc(4'hF, `CURREF_CFG_ADDR, 0, 8'h00);
      chk(last, `CURREF_CFG_RESET);
      chk({en, snk, rng, step, gate}, 0);
   endtask
   task automatic t_control();
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'hC5);
      chk({en, snk, rng, step}, {3'b111, 6'h05});
      chk(current, -40);
      acc(4'h0, `CURREF_CTRL_ADDR, 0, 8'h00);
      chk(last, 8'hC5);
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'h7F);
      chk(current, 504);
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'hC0);
      chk({en, snk, rng}, 3'b011);
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'h00);
      chk({en, snk, rng, step}, 0);
   endtask
   task automatic t_config();
      acc(4'hF, `CURREF_CFG_ADDR, 1, 8'hFF);
      acc(4'hF, `CURREF_CFG_ADDR, 0, 8'h00);
      chk(last, 8'h87);
      for (int c = 0; c < 8; c++) begin
         chan = (c < 6) ? 6'(1 << c) : 6'h3F;
         acc(4'hF, `CURREF_CFG_ADDR, 1, {5'h10, 3'(c)});
         chk(gate, c < 6);
         chan = (c < 6) ? ~6'(1 << c) : 6'h00;
         acc(4'hF, 8'hB8, 1, 8'h00);
         chk(gate, 0);
      end
      chan = 6'h3F;
      acc(4'hF, `CURREF_CFG_ADDR, 1, 8'h03);
      chk(gate, 0);
   endtask
   task automatic t_fine();
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'h04);
      acc(4'hF, `CURREF_CFG_ADDR, 1, 8'h80);
      chk(current, 6);
      chan = 6'h00;
      @(negedge mclk_in);
      @(negedge mclk_in);
      chk(current, 4);
      acc(4'h0, 8'hB8, 1, 8'hFF);
      acc(4'h0, 8'hB8, 0, 8'h00);
      chk(last, 8'h00);
      acc(4'h0, `CURREF_CTRL_ADDR, 0, 8'h00);
      chk(last, 8'h04);
   endtask
   // Decode: only the two page and address pairs hit
   task automatic t_decode();
      for (int k = 0; k < 4; k++) begin
         page = (k % 2 == 0) ? 4'h0 : 4'hF;
         addr = (k < 2) ? `CURREF_CTRL_ADDR : 8'hB8;
         @(negedge mclk_in);
         chk(hit, k < 2);
      end
      page = 4'h5;
      addr = `CURREF_CTRL_ADDR;
      @(negedge mclk_in);
      chk(hit, 0);
   endtask
   // Mid-run reset: both registers and every analog control output clear
   task automatic t_midreset();
      acc(4'h0, `CURREF_CTRL_ADDR, 1, 8'hC5);
      chan = 6'h3F;
      acc(4'hF, `CURREF_CFG_ADDR, 1, 8'h85);
      chk(gate, 1);
      chk(current, -56);
      rst_in = 1;
      repeat (2) @(negedge mclk_in);
      rst_in = 0;
      chk({en, snk, rng, step, gate}, 0);
      acc(4'h0, `CURREF_CTRL_ADDR, 0, 8'h00);
      chk(last, `CURREF_CTRL_RESET);
      acc(4'hF, `CURREF_CFG_ADDR, 0, 8'h00);
      chk(last, `CURREF_CFG_RESET);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for five cycles, then each scenario
   initial begin
      repeat (5) @(negedge mclk_in);
      rst_in = 0;
      t_reset();
      t_control();
      t_config();
      t_fine();
      t_decode();
      t_midreset();
      end_of_test();
   end
endmodule
